/* src/smc_standby_ctrl.sv */
// Purpose: Standby mode control with oscillation stabilization wait
// Assumes: Classic Wishbone slave, all inputs synchronous to CORE_CLK_I
// Notes:   Stop request bit clears itself when the standby state is entered
// Summary of operation
// - A write that sets the stop request bit leaves the wake masks unchanged.
// - The mode select bits act only while the stop request bit is one.
// - The stabilization wait counts only once the oscillator has started.
// - Wait select resets to 06H, giving 2**18 clocks of wait after reset.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
module smc_standby_ctrl #(
    parameter int WAIT_EXP_BASE = smc_pkg::WAIT_EXP_BASE_DEF
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        SRST_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [3:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        HALT_REQ_I,
    input  wire logic        NMI_A_I,
    input  wire logic        NMI_B_I,
    input  wire logic        INT_REQ_I,
    input  wire logic        OSC_STARTED_I,
    output logic             OSC_EN_O,
    output logic             CPU_RUN_O,
    output logic             PERIPH_RUN_O,
    output smc_pkg::smc_state_t STATE_O
);
    import smc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register and state storage
    smc_wake_mask_t          wake_mask, next_wake_mask;
    logic                    stop_req, next_stop_req;
    logic [MODE_SEL_W-1:0]   mode_sel, next_mode_sel;
    logic [OSC_SEL_W-1:0]    osc_sel, next_osc_sel;
    logic                    ack, next_ack;
    logic [31:0]             rdata, next_rdata;
    smc_state_t              state, next_state;
    logic [WAIT_CNT_W-1:0]   wait_cnt, next_wait_cnt;
    logic                    wake, bus_wr;

    // Wait length in clocks for a select value; values above 6 saturate
    function automatic logic [WAIT_CNT_W-1:0] wait_len(
        input logic [OSC_SEL_W-1:0] sel);
        logic [OSC_SEL_W-1:0] s;
        s = (sel > OSC_WAIT_SEL_RESET) ? OSC_WAIT_SEL_RESET : sel;
        wait_len = WAIT_CNT_W'(1) << (WAIT_EXP_BASE + int'(s));
    endfunction

    // Unmasked wake request from any of the three sources
    assign wake = (NMI_A_I & ~wake_mask.nmi_line_a_wake_mask)
                | (NMI_B_I & ~wake_mask.nmi_line_b_wake_mask)
                | (INT_REQ_I & ~wake_mask.maskable_wake_mask);

    // Write happens at the edge where the master sees ack
    assign bus_wr = CYC_I & STB_I & WE_I & ack & SEL_I[0];

    ////////////////////////////////////////////////////////////////////////
    // Register file and bus answer
    always_comb begin
        next_wake_mask = wake_mask;
        next_stop_req  = stop_req;
        next_mode_sel  = mode_sel;
        next_osc_sel   = osc_sel;
        next_ack       = CYC_I & STB_I & ~ack;
        next_rdata     = rdata;
        // Consume the request on entry; a write in the same cycle wins
        if (state == ST_RUN && stop_req) begin
            next_stop_req = 1'b0;
        end
        if (bus_wr) begin
            if (ADR_I == OFS_POWER_SAVE_CONTROL) begin
                next_stop_req = DAT_I[POS_STOP_REQUEST];
                // Masks written alongside a stop request are dropped
                if (!DAT_I[POS_STOP_REQUEST]) begin
                    next_wake_mask.maskable_wake_mask =
                        DAT_I[POS_MASKABLE_WM];
                    next_wake_mask.nmi_line_a_wake_mask = DAT_I[POS_NMI_A_WM];
                    next_wake_mask.nmi_line_b_wake_mask = DAT_I[POS_NMI_B_WM];
                end
            end else if (ADR_I == OFS_STANDBY_MODE_SEL) begin
                next_mode_sel = DAT_I[MODE_SEL_W-1:0];
            end else if (ADR_I == OFS_OSC_WAIT_SELECT) begin
                next_osc_sel = DAT_I[OSC_SEL_W-1:0];
            end
        end
        if (CYC_I && STB_I && !ack) begin
            next_rdata = 32'h0000_0000;
            if (ADR_I == OFS_POWER_SAVE_CONTROL) begin
                next_rdata[POS_STOP_REQUEST] = stop_req;
                next_rdata[POS_MASKABLE_WM]  = wake_mask.maskable_wake_mask;
                next_rdata[POS_NMI_A_WM]     = wake_mask.nmi_line_a_wake_mask;
                next_rdata[POS_NMI_B_WM]     = wake_mask.nmi_line_b_wake_mask;
            end else if (ADR_I == OFS_STANDBY_MODE_SEL) begin
                next_rdata[MODE_SEL_W-1:0] = mode_sel;
            end else if (ADR_I == OFS_OSC_WAIT_SELECT) begin
                next_rdata[OSC_SEL_W-1:0] = osc_sel;
            end else if (ADR_I == OFS_STATUS) begin
                next_rdata[2:0] = state;
            end
        end
    end

    // Register update; wait select comes up at 06H
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            wake_mask <= '0;
            stop_req  <= 1'b0;
            mode_sel  <= MODE_SEL_RESET;
            osc_sel   <= OSC_WAIT_SEL_RESET;
            ack       <= 1'b0;
            rdata     <= 32'h0000_0000;
        end else begin
            wake_mask <= next_wake_mask;
            stop_req  <= next_stop_req;
            mode_sel  <= next_mode_sel;
            osc_sel   <= next_osc_sel;
            ack       <= next_ack;
            rdata     <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Standby state machine and stabilization counter
    always_comb begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        case (state)
            ST_RUN: begin
                // Mode select is consulted only under a stop request
                if (stop_req) begin
                    if (mode_sel == SEL_LIGHT_IDLE) begin
                        next_state = ST_LIGHT_IDLE;
                    end else if (mode_sel == SEL_DEEP_IDLE) begin
                        next_state = ST_DEEP_IDLE;
                    end else begin
                        next_state = ST_STOP;
                    end
                end else if (HALT_REQ_I) begin
                    next_state = ST_HALT;
                end
            end
            // A request already pending still passes through halt
            ST_HALT: begin
                if (wake) begin
                    next_state = ST_RUN;
                end
            end
            ST_LIGHT_IDLE, ST_DEEP_IDLE: begin
                if (wake) begin
                    next_state = ST_RUN;
                end
            end
            ST_STOP: begin
                if (wake) begin
                    next_state    = ST_OSC_WAIT;
                    next_wait_cnt = '0;
                end
            end
            ST_OSC_WAIT: begin
                // Startup time of the oscillator is not part of the wait
                if (OSC_STARTED_I) begin
                    next_wait_cnt = wait_cnt + WAIT_CNT_W'(1);
                    if (next_wait_cnt >= wait_len(osc_sel)) begin
                        next_state = ST_RUN;
                    end
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // After reset the core waits for the oscillator as after a stop
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            state    <= ST_OSC_WAIT;
            wait_cnt <= '0;
        end else begin
            state    <= next_state;
            wait_cnt <= next_wait_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            OSC_EN_O     <= 1'b1;
            CPU_RUN_O    <= 1'b0;
            PERIPH_RUN_O <= 1'b0;
            STATE_O      <= ST_OSC_WAIT;
        end else begin
            OSC_EN_O     <= (next_state != ST_STOP);
            CPU_RUN_O    <= (next_state == ST_RUN);
            PERIPH_RUN_O <= (next_state == ST_RUN) || (next_state == ST_HALT);
            STATE_O      <= next_state;
        end
    end

    assign DAT_O = rdata;
    assign ACK_O = ack;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    // Masks survive a write that also requests standby
    a_mask_keep_stop: assert property (
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        bus_wr && ADR_I == OFS_POWER_SAVE_CONTROL && DAT_I[POS_STOP_REQUEST]
        |=> wake_mask == $past(wake_mask))
        else $error("wake masks changed by a stop request write");

    // Leaving run for a standby state needs the stop request
    a_mode_needs_stop: assert property (
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        $past(state) == ST_RUN
        && state inside {ST_LIGHT_IDLE, ST_DEEP_IDLE, ST_STOP}
        |-> $past(stop_req))
        else $error("standby entered without a stop request");

    // Counter frozen while the oscillator is still starting
    a_wait_hold_osc: assert property (
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        state == ST_OSC_WAIT && !OSC_STARTED_I
        |=> wait_cnt == $past(wait_cnt))
        else $error("wait counted before oscillator start");

    // First edge after release sees the reset select and the wait state
    a_osc_sel_reset: assert property (
        @(posedge CORE_CLK_I)
        $fell(SRST_I) |-> osc_sel == OSC_WAIT_SEL_RESET
        && state == ST_OSC_WAIT && !CPU_RUN_O)
        else $error("wrong state after reset release");

    // Halt is left for run, with the run output high, one edge after a wake request
    a_halt_wake_exit: assert property (
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        state == ST_HALT && wake |=> state == ST_RUN && CPU_RUN_O)
        else $error("halt not left on pending request");

    // Single cycle acknowledge per request
    a_ack_one_cycle: assert property (
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
endmodule // smc_standby_ctrl
`default_nettype wire

/* src/smc_pkg.sv */
// Purpose: Shared constants and types for the standby mode control block
// Assumes: 32-bit classic Wishbone register access, 100 MHz core clock
// Notes:   Register words are aligned; narrow fields sit in the low bits
package smc_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_POWER_SAVE_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STANDBY_MODE_SEL   = 4'h4;
    localparam logic [3:0] OFS_OSC_WAIT_SELECT    = 4'h8;
    localparam logic [3:0] OFS_STATUS             = 4'hC;

    // Field positions of power_save_control
    localparam int POS_STOP_REQUEST = 1;
    localparam int POS_MASKABLE_WM  = 4;
    localparam int POS_NMI_A_WM     = 5;
    localparam int POS_NMI_B_WM     = 6;

    // Field widths and reset values
    localparam int         MODE_SEL_W         = 2;
    localparam int         OSC_SEL_W          = 3;
    localparam logic [2:0] OSC_WAIT_SEL_RESET = 3'h6;
    localparam logic [1:0] MODE_SEL_RESET     = 2'h0;

    // Wait length is two to the power (base + select)
    localparam int         WAIT_EXP_BASE_DEF = 12;
    localparam int         WAIT_CNT_W        = 20;

    // Standby mode encodings of the mode-select field
    localparam logic [1:0] SEL_LIGHT_IDLE = 2'h1;
    localparam logic [1:0] SEL_DEEP_IDLE  = 2'h2;

    typedef struct packed {
        logic nmi_line_b_wake_mask;
        logic nmi_line_a_wake_mask;
        logic maskable_wake_mask;
    } smc_wake_mask_t;

    typedef enum logic [2:0] {
        ST_RUN        = 3'b000,
        ST_HALT       = 3'b001,
        ST_LIGHT_IDLE = 3'b010,
        ST_DEEP_IDLE  = 3'b011,
        ST_STOP       = 3'b100,
        ST_OSC_WAIT   = 3'b101
    } smc_state_t;
endpackage

/* dv/smc_standby_ctrl_tb.sv */
// Purpose: Self-checking bench for the standby mode control block
// Assumes: Wait exponent base set to 0, so select 6 gives 64 counted clocks
// Notes:   Bench drives every port itself; bus cycles are classic Wishbone
`timescale 1ns/1ps
`default_nettype none
module smc_standby_ctrl_tb;
    import smc_pkg::*;
    // Base cut to 0 to keep the run short; reset select still applies
    localparam int TB_WAIT_BASE = 0;
    localparam int RESET_WAIT   =
        1 << (TB_WAIT_BASE + int'(OSC_WAIT_SEL_RESET));
    logic        clk, srst, cyc, stb, we, halt, nmi_a, nmi_b, irq, osc_ok;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, q;
    logic        ack, osc_en, cpu_run, per_run;
    smc_state_t  st;
    int          err_count, samples_checked;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design under test
    always #5 clk = ~clk;
    smc_standby_ctrl #(.WAIT_EXP_BASE(TB_WAIT_BASE)) dut_u (
        .CORE_CLK_I(clk), .SRST_I(srst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat),
        .ACK_O(ack), .HALT_REQ_I(halt), .NMI_A_I(nmi_a), .NMI_B_I(nmi_b),
        .INT_REQ_I(irq), .OSC_STARTED_I(osc_ok), .OSC_EN_O(osc_en),
        .CPU_RUN_O(cpu_run), .PERIPH_RUN_O(per_run), .STATE_O(st));

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until ack is sampled high, then released
    task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 50) begin
            chk(32'h0, 32'h1);
            end_sim();
        end
    endtask
    task wait_st(input smc_state_t s, input int lim);
        int n;
        n = 0;
        while (st !== s && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk({29'h0, st}, {29'h0, s});
        if (st !== s) end_sim();
    endtask
    // Counted wait only advances while the oscillator reports running
    task wait_run(input int len);
        int n;
        n = 0;
        while (cpu_run !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        // Run shows one edge after the last counted clock
        chk(32'(n), 32'(len + 1));
        if (n >= 200) end_sim();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task test_reset_wait;
        repeat (100) @(posedge clk);
        chk({31'h0, cpu_run}, 32'h0);
        wb(OFS_OSC_WAIT_SELECT, 1'b0, 32'h0);
        chk(q, 32'h6);
        osc_ok <= 1'b1;
        wait_run(RESET_WAIT);
        $display("test reset wait done");
    endtask
    task test_mode_gate;
        wb(OFS_STANDBY_MODE_SEL, 1'b1, 32'h1);
        repeat (6) @(posedge clk);
        chk({29'h0, st}, {29'h0, ST_RUN});
        wb(OFS_POWER_SAVE_CONTROL, 1'b1, 32'h2);
        wait_st(ST_LIGHT_IDLE, 5);
        chk({31'h0, osc_en}, 32'h1);
        irq <= 1'b1;
        wait_st(ST_RUN, 5);
        irq <= 1'b0;
        $display("test mode gate done");
    endtask
    task test_stop_mask;
        wb(OFS_STANDBY_MODE_SEL, 1'b1, 32'h0);
        wb(OFS_POWER_SAVE_CONTROL, 1'b1, 32'h72);
        wait_st(ST_STOP, 5);
        osc_ok <= 1'b0;
        @(posedge clk);
        chk({31'h0, osc_en}, 32'h0);
        chk({31'h0, per_run}, 32'h0);
        irq <= 1'b1;
        wait_st(ST_OSC_WAIT, 5);
        repeat (20) @(posedge clk);
        chk({29'h0, st}, {29'h0, ST_OSC_WAIT});
        osc_ok <= 1'b1;
        wait_run(RESET_WAIT);
        irq <= 1'b0;
        $display("test stop mask done");
    endtask
    task test_halt;
        logic seen;
        seen = 1'b0;
        // Let the previous low level of irq reach the design first
        @(posedge clk);
        irq <= 1'b1;
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        repeat (6) begin
            @(posedge clk);
            if (st === ST_HALT) seen = 1'b1;
        end
        chk({31'h0, seen}, 32'h1);
        chk({29'h0, st}, {29'h0, ST_RUN});
        wb(OFS_POWER_SAVE_CONTROL, 1'b1, 32'h10);
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        repeat (10) @(posedge clk);
        chk({29'h0, st}, {29'h0, ST_HALT});
        chk({31'h0, per_run}, 32'h1);
        chk({31'h0, cpu_run}, 32'h0);
        nmi_a <= 1'b1;
        wait_st(ST_RUN, 5);
        nmi_a <= 1'b0;
        irq <= 1'b0;
        $display("test halt done");
    endtask
    // Deep idle, status read, short wait select, then a reset mid-run
    task test_deep_wait;
        wb(OFS_OSC_WAIT_SELECT, 1'b1, 32'h2);
        wb(OFS_OSC_WAIT_SELECT, 1'b0, 32'h0);
        chk(q, 32'h2);
        wb(OFS_STANDBY_MODE_SEL, 1'b1, 32'h2);
        irq <= 1'b1;
        wb(OFS_POWER_SAVE_CONTROL, 1'b1, 32'h10);
        wb(OFS_POWER_SAVE_CONTROL, 1'b1, 32'h2);
        wait_st(ST_DEEP_IDLE, 5);
        repeat (5) @(posedge clk);
        wb(OFS_STATUS, 1'b0, 32'h0);
        chk(q, {29'h0, ST_DEEP_IDLE});
        chk({31'h0, per_run}, 32'h0);
        nmi_b <= 1'b1;
        wait_st(ST_RUN, 5);
        nmi_b <= 1'b0;
        wb(OFS_STANDBY_MODE_SEL, 1'b1, 32'h0);
        wb(OFS_POWER_SAVE_CONTROL, 1'b1, 32'h2);
        wait_st(ST_STOP, 5);
        osc_ok <= 1'b0;
        nmi_b <= 1'b1;
        wait_st(ST_OSC_WAIT, 5);
        nmi_b <= 1'b0;
        osc_ok <= 1'b1;
        wait_run(1 << (TB_WAIT_BASE + 2));
        irq <= 1'b0;
        srst <= 1'b1;
        osc_ok <= 1'b0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        wb(OFS_OSC_WAIT_SELECT, 1'b0, 32'h0);
        chk(q, {29'h0, OSC_WAIT_SEL_RESET});
        chk({31'h0, cpu_run}, 32'h0);
        osc_ok <= 1'b1;
        wait_run(RESET_WAIT);
        $display("test deep wait done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 0; srst = 1; cyc = 0; stb = 0; we = 0; adr = 4'h0;
        sel = 4'hF; wdat = 32'h0; halt = 0; nmi_a = 0; nmi_b = 0;
        irq = 0; osc_ok = 0; err_count = 0; samples_checked = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        test_reset_wait();
        test_mode_gate();
        test_stop_mask();
        test_halt();
        test_deep_wait();
        end_sim();
    end
endmodule // smc_standby_ctrl_tb
`default_nettype wire
